// file: tdm_port.sv
// TDM serial audio output port with clock roles, speed modes and configuration source.
`timescale 1ns/1ns
// Function
// R1: Master bit clock is 256 times Fs.
// R2: Master frame sync high 128 bit clocks.
// R3: Slave frame sync high 1 to 244.
// R4: Three speed ranges split at 54, 108 kHz.
// R5: Frame sync stable before bit-clock rise.
// R6: Receiver samples data on rising edge.
// R7: Duty 50 percent, or 33 when selected.
// R8: Bit clock duty follows master clock; here the phase count alone fixes it.
// R9: Slave master may use any ratio.
// R10: Stand-alone takes configuration from straps only.
// R11: Straps held stable during stand-alone use.
// R12: Control mode repurposes four strap pins.
// R13: Controller sets control bit 7 to enter.
// R14: Register mode ignores straps, uses registers.
// R15: Master clock from crystal or external.
// R16: Crystal mode buffers crystal onto clock pin.
// R17: Frame sync rise starts eight-channel frame.
// R18: 32-cycle slots, left justified, MSB first.
// R19: Codes 00,01,10 master speeds; 11 slave.
// R20: Data changes on falling bit-clock edge.
// R21: Trailing slot bits are driven zero.
module tdm_port
  import tdm_port_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        speed_select_hi_i,
  input  wire logic        speed_select_lo_i,
  input  wire logic        duty_select_i,
  input  wire logic        crystal_enable_i,
  input  wire logic        crystal_input_i,
  output logic             crystal_drive_out_o,
  output logic             master_clock_o,
  output logic             master_clock_oe_o,
  input  wire logic        bit_clock_i,
  output logic             bit_clock_o,
  output logic             bit_clock_oe_o,
  input  wire logic        frame_sync_i,
  output logic             frame_sync_o,
  output logic             frame_sync_oe_o,
  output logic             tdm_audio_out_o,
  input  wire frame_t      sample_frame_i,
  output logic             frame_start_o,
  output logic             control_port_active_o
);

  logic [1:0]  rst_pipe_q;
  logic        rst_n;
  logic [3:0]  strap_s;
  logic [1:0]  link_s;
  logic        bclk_s;
  logic        fs_s;
  logic [7:0]  ctrl_q;
  cfg_t        cfg_d;
  cfg_t        cfg_q;
  logic        master;
  logic        ack_q;
  logic [31:0] rdata_d;
  logic [2:0]  prescale;
  logic [1:0]  phases;
  logic [2:0]  pre_q;
  logic [1:0]  phase_q;
  logic [1:0]  phase_d;
  logic        tick;
  logic        m_fall;
  logic        bclk_prev_q;
  logic        fs_rise_q;
  logic        s_rise;
  logic        s_fall;
  logic        s_frame;
  logic        fall_evt;
  logic        new_frame;
  logic [7:0]  bit_cnt_q;
  frame_t      frame_q;
  logic [4:0]  bit_pos;
  logic [4:0]  bit_sel;
  logic        bit_val;
  logic [15:0] period_q;
  logic [1:0]  det_speed_q;
  logic [1:0]  locked_q;
  logic [15:0] frames_q;

  // The reset is released through two flops so every flop on rst_n leaves reset on the same edge.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  sync_two_ff #(.W(4)) u_strap_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .d_i     ({speed_select_hi_i, speed_select_lo_i, duty_select_i, crystal_enable_i}),
    .q_o     (strap_s)
  ); // R11

  sync_two_ff #(.W(2)) u_link_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .d_i     ({bit_clock_i, frame_sync_i}),
    .q_o     (link_s)
  );
  assign bclk_s = link_s[1];
  assign fs_s   = link_s[0];

  // Straps steer the port until software sets the register-mode bit.
  always_comb begin
    if (ctrl_q[CTRL_REG_BIT]) begin
      cfg_d = '{reg_mode: 1'b1, crystal_sel: ctrl_q[CTRL_XTAL_BIT],
                duty_sel: ctrl_q[CTRL_DUTY_BIT],
                speed: ctrl_q[CTRL_SPEED_LSB +: 2]}; // R14
    end else begin
      cfg_d = '{reg_mode: 1'b0, crystal_sel: strap_s[0], duty_sel: strap_s[1],
                speed: strap_s[3:2]}; // R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (ce_i) begin
      cfg_q <= cfg_d;
    end
  end

  assign master                = (cfg_q.speed != SPEED_SLAVE); // R19
  assign control_port_active_o = cfg_q.reg_mode; // R12

  // The clock pin is a plain buffer path; it is not retimed, which would divide it.
  assign master_clock_o      = crystal_input_i & cfg_q.crystal_sel; // R16
  assign master_clock_oe_o   = cfg_q.crystal_sel; // R15
  assign crystal_drive_out_o = ~crystal_input_i & cfg_q.crystal_sel;

  // One wait cycle per access; the request is taken when ack_q is high.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack_q & ce_i);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce_i && avs_write_i && ack_q && avs_byteenable_i[0] &&
                 avs_address_i == GLOBAL_CTRL_OFS) begin
      ctrl_q <= avs_writedata_i[7:0] & CTRL_MASK; // R13
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    case (avs_address_i)
      GLOBAL_CTRL_OFS: begin
        rdata_d[7:0] = ctrl_q;
      end
      STATUS_OFS: begin
        rdata_d[STAT_SPEED_LSB +: 2] = master ? cfg_q.speed : det_speed_q;
        rdata_d[STAT_MASTER]         = master;
        rdata_d[STAT_REG_MODE]       = cfg_q.reg_mode;
        rdata_d[STAT_XTAL]           = cfg_q.crystal_sel;
        rdata_d[STAT_LOCKED]         = master | locked_q[1];
      end
      FRAME_COUNT_OFS: begin
        rdata_d[15:0] = frames_q;
      end
      default: begin
        rdata_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0;
    end else if (ce_i && avs_read_i && !ack_q) begin
      avs_readdata_o <= rdata_d;
    end
  end

  // Master bit clock: high for one phase, low for one or two, so its edges sit on
  // system clock rising edges and its duty is set by the phase count alone.
  always_comb begin
    case (cfg_q.speed)
      SPEED_SSM: prescale = PRESCALE_SSM;
      SPEED_DSM: prescale = PRESCALE_DSM;
      default:   prescale = PRESCALE_QSM;
    endcase
  end
  assign phases = cfg_q.duty_sel ? 2'h3 : 2'h2; // R7
  assign tick   = master && (pre_q == prescale - 3'h1); // R8

  always_comb begin
    phase_d = phase_q;
    if (!master) begin
      phase_d = 2'h0;
    end else if (tick) begin
      phase_d = (phase_q == phases - 2'h1) ? 2'h0 : phase_q + 2'h1;
    end
  end
  assign m_fall = tick && (phase_q == 2'h0);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_q       <= 3'h0;
      phase_q     <= 2'h0;
      bit_clock_o <= 1'b0;
    end else if (ce_i) begin
      pre_q       <= (!master || tick) ? 3'h0 : pre_q + 3'h1;
      phase_q     <= phase_d;
      bit_clock_o <= master && (phase_d == 2'h0); // R7
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_clock_oe_o  <= 1'b0;
      frame_sync_oe_o <= 1'b0;
    end else if (ce_i) begin
      bit_clock_oe_o  <= master; // R19
      frame_sync_oe_o <= master;
    end
  end

  // Slave edges come from the synchronised bit clock; frame sync is judged at its rise.
  assign s_rise  = !master && bclk_s && !bclk_prev_q;
  assign s_fall  = !master && !bclk_s && bclk_prev_q;
  assign s_frame = s_rise && fs_s && !fs_rise_q; // R3

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev_q <= 1'b0;
      fs_rise_q   <= 1'b0;
    end else if (ce_i) begin
      bclk_prev_q <= bclk_s;
      if (s_rise) begin
        fs_rise_q <= fs_s;
      end
    end
  end

  assign fall_evt  = m_fall || s_fall;
  assign new_frame = master ? (m_fall && bit_cnt_q == 8'hFF) : s_frame; // R1 R17

  // Bit index within the frame: slot in the top three bits, position in the low five.
  assign bit_pos = bit_cnt_q[4:0];
  assign bit_sel = 5'(SAMPLE_W - 1) - bit_pos;
  assign bit_val = (bit_pos < 5'(SAMPLE_W)) ? frame_q[bit_cnt_q[7:5]][bit_sel] : 1'b0; // R21

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q       <= 8'h00;
      tdm_audio_out_o <= 1'b0;
    end else if (ce_i) begin
      if (fall_evt) begin
        bit_cnt_q       <= bit_cnt_q + 8'h01;
        tdm_audio_out_o <= bit_val; // R20
      end else if (s_frame) begin
        bit_cnt_q <= 8'h00; // R17
      end
    end
  end

  // The frame sync rises one bit ahead of the first MSB, on the same falling edge.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_o <= 1'b0;
    end else if (ce_i) begin
      if (!master) begin
        frame_sync_o <= 1'b0;
      end else if (m_fall) begin // R5
        frame_sync_o <= ((bit_cnt_q + 8'h01) < 8'(FS_HIGH_BITS)); // R2
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_q       <= '0;
      frame_start_o <= 1'b0;
      frames_q      <= 16'h0000;
    end else if (ce_i) begin
      frame_start_o <= new_frame;
      if (new_frame) begin
        frame_q  <= sample_frame_i; // R18
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  // Slave speed detection from the frame period; any bit-clock ratio is accepted.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      period_q    <= 16'h0000;
      det_speed_q <= SPEED_SSM;
      locked_q    <= 2'h0;
    end else if (ce_i) begin
      if (master) begin
        period_q <= 16'h0000;
        locked_q <= 2'h0;
      end else if (s_frame) begin
        period_q <= 16'h0001;
        locked_q <= {locked_q[0], 1'b1};
        if (period_q >= 16'(DSM_EDGE_CLKS)) begin
          det_speed_q <= SPEED_SSM; // R4
        end else if (period_q >= 16'(QSM_EDGE_CLKS)) begin
          det_speed_q <= SPEED_DSM;
        end else begin
          det_speed_q <= SPEED_QSM; // R9
        end
      end else if (period_q != 16'hFFFF) begin
        period_q <= period_q + 16'h0001;
      end
    end
  end

  // Helper state read only by the checks below.
  logic [1:0] settle_q;
  logic [8:0] hi_run_q;
  logic [8:0] fall_run_q;
  logic [3:0] lvl_run_q;
  logic [3:0] hi_last_q;
  logic       settled;
  logic       msb_now;

  assign settled = (settle_q == 2'h3);
  assign msb_now = frame_q[bit_cnt_q[7:5]][SAMPLE_W-1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_q   <= 2'h0;
      hi_run_q   <= 9'h000;
      fall_run_q <= 9'h000;
      lvl_run_q  <= 4'h0;
      hi_last_q  <= 4'h0;
    end else if (ce_i) begin
      if (cfg_d != cfg_q) begin
        settle_q <= 2'h0;
      end else if (new_frame && !settled) begin
        settle_q <= settle_q + 2'h1;
      end
      if (m_fall) begin
        hi_run_q   <= frame_sync_o ? hi_run_q + 9'h001 : 9'h000;
        fall_run_q <= (bit_cnt_q == 8'hFF) ? 9'h001 : fall_run_q + 9'h001;
      end
      lvl_run_q <= ((master && phase_d == 2'h0) != bit_clock_o) ? 4'h1 : lvl_run_q + 4'h1;
      if (bit_clock_o && !(master && phase_d == 2'h0)) begin
        hi_last_q <= lvl_run_q;
      end
    end
  end

  sequence fs_rise_s;
    $rose(frame_sync_o);
  endsequence

  sequence bclk_fall_s;
    $fell(bit_clock_o);
  endsequence

  fs_width_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R2
    (master && settled && $fell(frame_sync_o)) |-> (hi_run_q == 9'(FS_HIGH_BITS)))
    else $error("frame sync high width is not 128 bit clocks");

  frame_len_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R1
    (master && settled) ##0 fs_rise_s |-> ($past(fall_run_q) == 9'(FRAME_BITS)))
    else $error("frame is not 256 bit clocks long");

  duty_ratio_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R7
    (master && settled && $rose(bit_clock_o)) |->
      ($past(lvl_run_q) == (cfg_q.duty_sel ? {hi_last_q[2:0], 1'b0} : hi_last_q)))
    else $error("bit clock low time does not match duty setting");

  fs_on_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R5
    (master && settled && $changed(frame_sync_o)) |-> bclk_fall_s)
    else $error("frame sync changed away from a falling bit clock edge");

  data_on_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R20
    $changed(tdm_audio_out_o) |-> $past(fall_evt))
    else $error("serial data changed without a falling bit clock edge");

  trail_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R21
    (fall_evt && bit_pos >= 5'(SAMPLE_W)) |=> !tdm_audio_out_o)
    else $error("trailing slot bit is not zero");

  msb_first_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R18
    (fall_evt && bit_pos == 5'h00) |=> (tdm_audio_out_o == $past(msb_now)))
    else $error("slot does not start with the sample MSB");

  slave_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R17
    s_frame |=> (bit_cnt_q == 8'h00) ##0 frame_start_o)
    else $error("slave frame sync rise did not restart the frame");

  strap_cfg_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R10
    !ctrl_q[CTRL_REG_BIT] |=> (cfg_q.speed == $past(strap_s[3:2]) && !cfg_q.reg_mode))
    else $error("stand-alone mode does not follow the straps");

  reg_cfg_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R14
    ctrl_q[CTRL_REG_BIT] |=> (cfg_q.speed == $past(ctrl_q[1:0]) &&
                              cfg_q.duty_sel == $past(ctrl_q[CTRL_DUTY_BIT])))
    else $error("register mode still follows the straps");

  role_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i) // R19
    $past(rst_n) |-> (bit_clock_oe_o == $past(master) && frame_sync_oe_o == $past(master)))
    else $error("clock pin drive does not match the role code");

endmodule

// file: tdm_port_pkg.sv
// Shared constants, field layouts and carrier types of the TDM serial audio port.
package tdm_port_pkg;

  localparam int CLK_HZ       = 25_000_000;
  localparam int CHANNELS     = 8;
  localparam int SAMPLE_W     = 24;
  localparam int SLOT_BITS    = 32;
  localparam int FRAME_BITS   = 256;
  localparam int FS_HIGH_BITS = 128;

  // Sample-rate range limits of the speed modes, in kHz.
  localparam int SSM_MIN_KHZ = 2;
  localparam int SSM_MAX_KHZ = 54;
  localparam int DSM_MAX_KHZ = 108;
  localparam int QSM_MAX_KHZ = 216;

  // Frame periods, in system clocks, at the speed-mode boundaries.
  localparam int DSM_EDGE_CLKS = CLK_HZ / (SSM_MAX_KHZ * 1000);
  localparam int QSM_EDGE_CLKS = CLK_HZ / (DSM_MAX_KHZ * 1000);

  // Speed-select codes.
  localparam logic [1:0] SPEED_SSM   = 2'h0;
  localparam logic [1:0] SPEED_DSM   = 2'h1;
  localparam logic [1:0] SPEED_QSM   = 2'h2;
  localparam logic [1:0] SPEED_SLAVE = 2'h3;

  // System clocks per bit-clock phase in master role.
  localparam logic [2:0] PRESCALE_SSM = 3'h4;
  localparam logic [2:0] PRESCALE_DSM = 3'h2;
  localparam logic [2:0] PRESCALE_QSM = 3'h1;

  // Register byte offsets.
  localparam logic [3:0] GLOBAL_CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS      = 4'h4;
  localparam logic [3:0] FRAME_COUNT_OFS = 4'h8;

  // Global control fields.
  localparam int         CTRL_SPEED_LSB = 0;
  localparam int         CTRL_DUTY_BIT  = 2;
  localparam int         CTRL_XTAL_BIT  = 3;
  localparam int         CTRL_REG_BIT   = 7;
  localparam logic [7:0] CTRL_MASK      = 8'h8F;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // Status fields.
  localparam int STAT_SPEED_LSB = 0;
  localparam int STAT_MASTER    = 2;
  localparam int STAT_REG_MODE  = 3;
  localparam int STAT_XTAL      = 4;
  localparam int STAT_LOCKED    = 5;

  typedef struct packed {
    logic       reg_mode;
    logic       crystal_sel;
    logic       duty_sel;
    logic [1:0] speed;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{reg_mode: 1'b0, crystal_sel: 1'b0, duty_sel: 1'b0,
                                  speed: SPEED_SSM};

  typedef logic [CHANNELS-1:0][SAMPLE_W-1:0] frame_t;

endpackage

// file: sync_two_ff.sv
// Two flip-flop synchroniser for signals from outside the clock domain.
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// file: tdm_receiver_model.sv
// Far-side receiver of the TDM stream that can also act as clock master.
`timescale 1ns/1ns
module tdm_receiver_model
  import tdm_port_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         bit_clock_i,
  input  wire logic         frame_sync_i,
  input  wire logic         audio_i,
  input  wire logic         drive_i,
  input  wire logic [7:0]   fs_width_i,
  output logic              bit_clock_o,
  output logic              frame_sync_o,
  output logic      [255:0] frame_bits_o,
  output int                frames_o,
  output int                bits_seen_o,
  output int                fs_width_seen_o
);
  logic [255:0] shift_q;
  logic         fs_prev_q;
  int           nbits;
  int           nhigh;

  always @(posedge bit_clock_i) begin
    shift_q = {shift_q[254:0], audio_i};
    nbits = nbits + 1;
    if (frame_sync_i && !fs_prev_q) begin
      bits_seen_o = nbits;
      fs_width_seen_o = nhigh;
      frame_bits_o = shift_q;
      frames_o = frames_o + 1;
      nbits = 0;
      nhigh = 0;
    end
    if (frame_sync_i) begin
      nhigh = nhigh + 1;
    end
    fs_prev_q = frame_sync_i;
  end

  // The link clock stands still while idle, so the device sees only frame sync toggling and no bit clock edges.
  initial begin
    shift_q = '0;
    fs_prev_q = 1'b0;
    nbits = 0;
    nhigh = 0;
    frames_o = 0;
    bits_seen_o = 0;
    fs_width_seen_o = 0;
    frame_bits_o = '0;
    bit_clock_o = 1'b0;
    frame_sync_o = 1'b0;
    @(posedge clk_i);
    #35;
    forever begin
      if (drive_i) begin
        for (int b = 0; b < FRAME_BITS; b++) begin
          frame_sync_o = (b < int'(fs_width_i));
          #160;
          bit_clock_o = 1'b1;
          #160;
          bit_clock_o = 1'b0;
        end
      end else begin
        frame_sync_o = ~frame_sync_o;
        #320;
      end
    end
  end
endmodule

// file: tdm_port_bench.sv
// Self-checking testbench of the TDM serial audio port.
`timescale 1ns/1ns
module tdm_port_bench
  import tdm_port_pkg::*;
;
  typedef struct packed {
    logic [1:0] spd;
    logic       duty;
    logic [2:0] pre;
    logic [3:0] per;
  } row_t;

  logic clk_i, reset_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]   avs_address_i, avs_byteenable_i;
  logic [31:0]  avs_writedata_i, avs_readdata_o;
  logic speed_select_hi_i, speed_select_lo_i, duty_select_i, crystal_enable_i;
  logic crystal_input_i, crystal_drive_out_o, master_clock_o, master_clock_oe_o;
  logic bit_clock_i, bit_clock_o, bit_clock_oe_o, frame_sync_i, frame_sync_o;
  logic frame_sync_oe_o, tdm_audio_out_o, frame_start_o, control_port_active_o;
  logic m_bclk, m_fs, m_drive;
  logic [7:0]   m_width;
  logic [255:0] rx_bits;
  frame_t       sample_frame_i;
  int           rx_frames, rx_len, rx_fsw;
  int           fail_count = 0;
  int           n_checks = 0;
  row_t         rows [5] = '{'{SPEED_SSM, 1'b0, PRESCALE_SSM, 4'h8},
                             '{SPEED_DSM, 1'b0, PRESCALE_DSM, 4'h4},
                             '{SPEED_QSM, 1'b0, PRESCALE_QSM, 4'h2},
                             '{SPEED_SSM, 1'b1, PRESCALE_SSM, 4'hC},
                             '{SPEED_QSM, 1'b1, PRESCALE_QSM, 4'h3}};

  // Each shared pin carries whichever party has its driver enabled.
  assign bit_clock_i  = bit_clock_oe_o ? bit_clock_o : m_bclk;
  assign frame_sync_i = frame_sync_oe_o ? frame_sync_o : m_fs;

  tdm_port dut (.clk_i, .reset_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .speed_select_hi_i, .speed_select_lo_i, .duty_select_i, .crystal_enable_i,
    .crystal_input_i, .crystal_drive_out_o, .master_clock_o, .master_clock_oe_o,
    .bit_clock_i, .bit_clock_o, .bit_clock_oe_o, .frame_sync_i, .frame_sync_o,
    .frame_sync_oe_o, .tdm_audio_out_o, .sample_frame_i, .frame_start_o,
    .control_port_active_o);

  tdm_receiver_model partner (.clk_i(clk_i), .bit_clock_i(bit_clock_i),
    .frame_sync_i(frame_sync_i), .audio_i(tdm_audio_out_o), .drive_i(m_drive),
    .fs_width_i(m_width), .bit_clock_o(m_bclk), .frame_sync_o(m_fs),
    .frame_bits_o(rx_bits), .frames_o(rx_frames), .bits_seen_o(rx_len),
    .fs_width_seen_o(rx_fsw));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    crystal_input_i <= ~crystal_input_i;
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_frame(input string what, input logic [255:0] exp);
    n_checks++;
    if (rx_bits !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, rx_bits);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    fail_count++;
    $display("wrong value %s expected completion seen timeout", what);
    print_verdict();
  endtask

  task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= 4'hF;
    avs_write_i <= w;
    avs_read_i <= ~w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 20) timeout("waitrequest");
  endtask

  task automatic wait_frames(input int k);
    int start;
    int n;
    start = rx_frames;
    for (n = 0; n < 40000 && rx_frames < start + k; n++) @(posedge clk_i);
    if (n == 40000) timeout("frame count");
  endtask

  task automatic measure_bclk(output int hi, output int per);
    int n;
    hi = 0;
    for (n = 0; n < 50 && bit_clock_o !== 1'b0; n++) @(negedge clk_i);
    if (n == 50) timeout("bit clock low");
    for (n = 0; n < 50 && bit_clock_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 50) timeout("bit clock high");
    while (bit_clock_o === 1'b1 && hi < 50) begin
      hi++;
      @(negedge clk_i);
    end
    per = hi;
    while (bit_clock_o === 1'b0 && per < 50) begin
      per++;
      @(negedge clk_i);
    end
  endtask

  function automatic logic [255:0] exp_bits(input frame_t f);
    logic [255:0] e;
    e = '0;
    for (int c = 0; c < CHANNELS; c++) e[255 - SLOT_BITS * c -: SAMPLE_W] = f[c];
    return e;
  endfunction

  initial begin
    int hi;
    int per;
    logic [31:0] q;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
    {speed_select_hi_i, speed_select_lo_i, duty_select_i, crystal_enable_i} = 4'h0;
    crystal_input_i = 1'b0;
    m_drive = 1'b0;
    m_width = 8'h01;
    for (int c = 0; c < CHANNELS; c++) sample_frame_i[c] = 24'hC0FFE0 + 24'(c * 7);
    repeat (3) @(posedge clk_i);
    check_word("outputs in reset", 32'h0, {26'h0, bit_clock_oe_o, frame_sync_oe_o,
      tdm_audio_out_o, frame_start_o, control_port_active_o, master_clock_oe_o});
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    av_xfer(1'b0, GLOBAL_CTRL_OFS, 32'h0, q);
    check_word("control reset", {24'h0, CTRL_RESET}, q);
    for (int r = 0; r < 5; r++) begin
      {speed_select_hi_i, speed_select_lo_i} <= rows[r].spd;
      duty_select_i <= rows[r].duty;
      wait_frames(3);
      measure_bclk(hi, per);
      check_word("bit clock high", 32'(rows[r].pre), 32'(hi));
      check_word("bit clock period", 32'(rows[r].per), 32'(per));
      check_word("frame length", 32'(FRAME_BITS), 32'(rx_len));
      check_word("sync width", 32'(FS_HIGH_BITS), 32'(rx_fsw));
      check_frame("frame data", exp_bits(sample_frame_i));
      check_word("master enables", 32'h3, {30'h0, bit_clock_oe_o, frame_sync_oe_o});
      av_xfer(1'b0, STATUS_OFS, 32'h0, q);
      check_word("status", 32'h24 | 32'(rows[r].spd), q);
      $display("master row %0d finished", r);
    end
    @(posedge clk_i);
    crystal_enable_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_i);
      check_word("clock pins", {29'h0, crystal_input_i, ~crystal_input_i, 1'b1},
        {29'h0, master_clock_o, crystal_drive_out_o, master_clock_oe_o});
    end
    @(posedge clk_i);
    crystal_enable_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check_word("clock pin released", 32'h0, {31'h0, master_clock_oe_o});
    $display("crystal test finished");
    av_xfer(1'b1, GLOBAL_CTRL_OFS, 32'hFF, q);
    av_xfer(1'b0, GLOBAL_CTRL_OFS, 32'h0, q);
    check_word("control readback", 32'h8F, q);
    check_word("register mode", 32'h3, {30'h0, control_port_active_o, master_clock_oe_o});
    av_xfer(1'b1, GLOBAL_CTRL_OFS, 32'h81, q);
    @(posedge clk_i);
    {speed_select_hi_i, speed_select_lo_i, duty_select_i, crystal_enable_i} <= 4'hF;
    wait_frames(3);
    measure_bclk(hi, per);
    check_word("register speed", {PRESCALE_DSM, 8'(2 * PRESCALE_DSM)}, {3'(hi), 8'(per)});
    av_xfer(1'b0, FRAME_COUNT_OFS, 32'h0, q);
    hi = int'(q);
    wait_frames(2);
    av_xfer(1'b0, FRAME_COUNT_OFS, 32'h0, q);
    check_word("frame count step", 32'h2, q - 32'(hi));
    check_word("straps ignored", 32'h6, {29'h0, bit_clock_oe_o, frame_sync_oe_o,
      master_clock_oe_o});
    av_xfer(1'b1, 4'hC, 32'hFF, q);
    av_xfer(1'b0, 4'hC, 32'h0, q);
    check_word("unmapped read", 32'h0, q);
    av_xfer(1'b0, GLOBAL_CTRL_OFS, 32'h0, q);
    check_word("control kept", 32'h81, q);
    av_xfer(1'b0, STATUS_OFS, 32'h0, q);
    check_word("register status", 32'h2D, q);
    $display("register test finished");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_word("mid reset", 32'h0, {30'h0, control_port_active_o, bit_clock_oe_o});
    reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    av_xfer(1'b0, GLOBAL_CTRL_OFS, 32'h0, q);
    check_word("control after reset", {24'h0, CTRL_RESET}, q);
    check_word("slave enables", 32'h0, {30'h0, bit_clock_oe_o, frame_sync_oe_o});
    sample_frame_i <= ~sample_frame_i;
    m_drive <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      m_width <= (w == 0) ? 8'h01 : 8'hF4;
      wait_frames(4);
      check_frame("slave frame data", exp_bits(sample_frame_i));
      av_xfer(1'b0, STATUS_OFS, 32'h0, q);
      check_word("slave status", 32'h30, q);
      $display("slave width %0d finished", m_width);
    end
    m_drive <= 1'b0;
    print_verdict();
  end
endmodule
